// File: hb_fault_pkg.sv
package hb_fault_pkg;
  // timebase of the control logic
  localparam int unsigned CLK_PERIOD_NS = 50;
  // delays in microseconds as defaults; no figure is printed, so plain values
  localparam int unsigned STANDBY_DELAY_US = 100;
  localparam int unsigned FAULT_RESET_TIME_US = 10;
  localparam int unsigned CURRENT_LIMIT_TIME_US = 50;
  localparam int unsigned UNDERVOLTAGE_DELAY_US = 20;
  // cycle counts, least times rounded up
  localparam int unsigned STANDBY_CYC =
    (STANDBY_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FAULT_RESET_CYC =
    (FAULT_RESET_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CURRENT_LIMIT_CYC =
    (CURRENT_LIMIT_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // fault flag release after current limit: 1.5 times the switching time
  localparam int unsigned CL_FLAG_CYC = (CURRENT_LIMIT_CYC * 3 + 1) / 2;
  localparam int unsigned UNDERVOLTAGE_CYC =
    (UNDERVOLTAGE_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // counter width shared by every timer
  localparam int unsigned CNT_W = 16;
  // sense output selection
  typedef enum logic [1:0] {
    SENSE_OFFSET,
    SENSE_LOAD,
    SENSE_FAULT,
    SENSE_FLOAT
  } sense_mode_t;
endpackage : hb_fault_pkg

// File: hb_sync3.sv
`timescale 1ns/1ps
// three-stage synchroniser: output moves once stages two and three agree
module hb_sync3 (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // raw pin level
  input wire logic i_pin,
  // filtered level
  output logic o_level
);
  logic s1; // metastability stage, read only by s2
  logic s2;
  logic s3;

  // shift chain
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= i_pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // accept only when the last two stages agree
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_level <= 1'b0;
    end else if (s2 == s3) begin
      o_level <= s3;
    end
  end
endmodule : hb_sync3

// File: hb_fault_ctrl.sv
`timescale 1ns/1ps
// Notes on behaviour
// [RULE1] no stand-by while any fault present
// [RULE2] latched fault cleared by both inputs low
// [RULE3] current limit: resume tCL, flag 1.5x
// [RULE4] undervoltage recovery and flag after delay
// [RULE5] undervoltage forces both switches off, fault
// [RULE6] both low past delay, no fault: stand-by
// [RULE7] overtemp/overcurrent: both off, latch, flag
// [RULE8] all delays counted on internal timebase
module hb_fault_ctrl (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // host logic inputs (pins)
  input wire logic i_control_input,
  input wire logic i_inhibit_input,
  // analogue monitors (asynchronous)
  input wire logic i_overtemp,
  input wire logic i_overcurrent,
  input wire logic i_current_limit,
  input wire logic i_undervoltage,
  // switch drive
  output logic o_high_side_switch,
  output logic o_low_side_switch,
  // sense output control
  output hb_fault_pkg::sense_mode_t o_sense_output,
  output logic o_fault,
  output logic o_standby
);
  // timer end points, cut on purpose to the 16-bit counters
  // every figure here fits well inside the counter range
  localparam logic [15:0] STBY_N = 16'(hb_fault_pkg::STANDBY_CYC);
  localparam logic [15:0] RST_N = 16'(hb_fault_pkg::FAULT_RESET_CYC);
  localparam logic [15:0] CL_N = 16'(hb_fault_pkg::CURRENT_LIMIT_CYC);
  localparam logic [15:0] CLF_N = 16'(hb_fault_pkg::CL_FLAG_CYC);
  localparam logic [15:0] UV_N = 16'(hb_fault_pkg::UNDERVOLTAGE_CYC);

  // pins and monitors after their synchronisers
  logic ctl; // synchronised control input
  logic inhibit_input; // synchronised inhibit input
  logic ot; // synchronised overtemperature
  logic oc; // synchronised overcurrent
  logic cl; // synchronised current-limit event
  logic uv; // synchronised undervoltage

  // every asynchronous input gets its own synchroniser
  // a level must stand two samples to pass, so one-cycle glitches are dropped;
  // the price is four cycles of latency on every pin and monitor
  hb_sync3 u_s_ctl (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_pin(i_control_input), .o_level(ctl));
  hb_sync3 u_s_inh (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_pin(i_inhibit_input), .o_level(inhibit_input));
  hb_sync3 u_s_ot (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_pin(i_overtemp), .o_level(ot));
  hb_sync3 u_s_oc (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_pin(i_overcurrent), .o_level(oc));
  hb_sync3 u_s_cl (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_pin(i_current_limit), .o_level(cl));
  hb_sync3 u_s_uv (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_pin(i_undervoltage), .o_level(uv));

  logic both_low; // host requests stand-by or fault reset
  assign both_low = !ctl && !inhibit_input;

  logic latched; // overtemp/overcurrent latch
  logic [15:0] low_cnt; // cycles both inputs have been low
  logic cl_active; // switching suppressed by current limit
  logic [15:0] cl_cnt; // time since the current limit ended
  logic cl_flag; // fault flag held for 1.5x
  logic uv_hold; // undervoltage or its recovery delay
  logic [15:0] uv_cnt; // time since the supply recovered
  logic any_fault; // any condition that forbids stand-by
  // live undervoltage, overtemperature and overcurrent count as well (current limit does not), so stand-by is refused in the first cycle
  // of a fault, before the latch or the hold flag has caught up
  assign any_fault = latched || cl_flag || uv_hold || uv || ot || oc; // [RULE1]

  // both-low timer, shared by stand-by and fault reset
  // it saturates instead of wrapping, so a long low phase never looks short
  // the count starts on the first edge at which both synchronised pins are low
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      low_cnt <= '0;
    end else if (!both_low) begin
      low_cnt <= '0;
    end else if (low_cnt != 16'hFFFF) begin
      low_cnt <= low_cnt + 16'h0001; // [RULE8]
    end
  end

  // fault latch: set wins over clear
  // a monitor that is still active keeps the latch set while the reset time runs
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      latched <= 1'b0;
    end else if (ot || oc) begin
      latched <= 1'b1; // [RULE7]
    end else if (both_low && low_cnt >= RST_N) begin
      latched <= 1'b0; // [RULE2]
    end
  end

  // current limitation: switching paused for the limit time, flag for 1.5x
  // both times run from the end of the limit event; a new event restarts them,
  // so a limit that keeps returning holds the flag up indefinitely
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cl_cnt <= '0;
      cl_active <= 1'b0;
      cl_flag <= 1'b0;
    end else if (cl) begin
      cl_cnt <= '0; // restart on each new limit event
      cl_active <= 1'b1;
      cl_flag <= 1'b1;
    end else if (cl_flag) begin
      cl_cnt <= cl_cnt + 16'h0001;
      if (cl_cnt + 16'h0001 >= CL_N) begin
        cl_active <= 1'b0; // [RULE3]
      end
      if (cl_cnt + 16'h0001 >= CLF_N) begin
        cl_flag <= 1'b0; // [RULE3]
      end
    end
  end

  // undervoltage hold: while low and for the delay after recovery
  // the delay restarts if the supply dips again before it has run out
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      uv_hold <= 1'b0;
      uv_cnt <= '0;
    end else if (uv) begin
      uv_hold <= 1'b1; // [RULE5]
      uv_cnt <= '0;
    end else if (uv_hold) begin
      uv_cnt <= uv_cnt + 16'h0001;
      if (uv_cnt + 16'h0001 >= UV_N) begin
        uv_hold <= 1'b0; // [RULE4]
      end
    end
  end

  // stand-by: only reachable without any fault
  // left at once when a pin rises or a fault appears
  // the sense output floats on the same edge, see the sense process
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_standby <= 1'b0;
    end else if (!both_low || any_fault) begin
      o_standby <= 1'b0; // [RULE1]
    end else if (low_cnt >= STBY_N) begin
      o_standby <= 1'b1; // [RULE6]
    end
  end

  // switch drive; current limit inverts the active switch while paused
  // both switches are registered together, so one edge never shows a mix
  // an inhibited bridge stays off even during a current-limit pause
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_high_side_switch <= 1'b0;
      o_low_side_switch <= 1'b0;
    end else if (latched || ot || oc || uv_hold || uv) begin
      o_high_side_switch <= 1'b0; // [RULE5] [RULE7]
      o_low_side_switch <= 1'b0;
    end else if (!inhibit_input) begin
      o_high_side_switch <= 1'b0; // inhibit input low: bridge inhibited, both off
      o_low_side_switch <= 1'b0;
    end else if (cl_active) begin
      o_high_side_switch <= !ctl; // freewheel through opposite switch
      o_low_side_switch <= ctl;
    end else begin
      o_high_side_switch <= ctl;
      o_low_side_switch <= !ctl;
    end
  end

  // sense output selection and fault flag
  // the fault current has priority over every other sense source
  // o_fault lags its causes by one cycle, like every other output
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_sense_output <= hb_fault_pkg::SENSE_OFFSET;
      o_fault <= 1'b0;
    end else begin
      o_fault <= any_fault;
      if (latched || ot || oc || cl_flag) begin
        o_sense_output <= hb_fault_pkg::SENSE_FAULT; // [RULE7] [RULE3]
      end else if (uv_hold) begin
        o_sense_output <= hb_fault_pkg::SENSE_OFFSET; // at most offset in undervoltage [RULE4]
      end else if (both_low && low_cnt >= STBY_N) begin
        o_sense_output <= hb_fault_pkg::SENSE_FLOAT; // [RULE6]
      end else if (inhibit_input && ctl) begin
        o_sense_output <= hb_fault_pkg::SENSE_LOAD;
      end else begin
        o_sense_output <= hb_fault_pkg::SENSE_OFFSET;
      end
    end
  end

  // assertions: stand-by and fault latch
  a_standby_no_fault: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RULE1]
    o_standby |-> !latched) else $error("stand-by with latched fault");
  a_latch_holds: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RULE2]
    latched && !both_low |=> latched) else $error("latch cleared without reset");
  a_fault_switches_off: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RULE7]
    latched |=> !o_high_side_switch && !o_low_side_switch) else $error("switch on in fault");
  a_fault_sense: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RULE7]
    latched |=> o_sense_output == hb_fault_pkg::SENSE_FAULT) else $error("no fault flag");
  a_fault_output: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RULE7]
    latched || ot || oc |=> o_fault) else $error("fault output missing");
  // assertions: undervoltage
  a_uv_off: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RULE5]
    uv |=> !o_high_side_switch && !o_low_side_switch && o_fault) else $error("uv drive");
  a_uv_release: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RULE4]
    $fell(uv) |-> uv_hold && uv_cnt == 16'h0000) else $error("uv hold missing");
  a_uv_recovery_off: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RULE4]
    uv_hold |=> !o_high_side_switch && !o_low_side_switch) else $error("switch on in uv delay");
  // assertions: current limitation
  a_cl_flag_after: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RULE3]
    cl_flag && !cl_active && !cl |-> cl_cnt >= CL_N - 16'h0001) else $error("flag vs cl");
  a_cl_resume_time: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RULE3]
    $fell(cl_active) |-> cl_cnt == CL_N) else $error("limit time wrong");
  // assertions: stand-by entry
  a_standby_entry: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RULE6]
    both_low && !any_fault && low_cnt >= STBY_N |=> o_standby) else $error("no stand-by");
  a_standby_sense: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RULE6]
    o_standby |-> o_sense_output == hb_fault_pkg::SENSE_FLOAT) else $error("sense not floating");
endmodule : hb_fault_ctrl

// File: hb_host_model.sv
`timescale 1ns/1ps
// host controller: owns the two logic pins, moves them after a falling edge
module hb_host_model (
  // clock
  input wire logic i_clk,
  // logic pins towards the device
  output logic o_control_input,
  output logic o_inhibit_input
);
  // idle low, as a port straight out of reset
  initial begin
    o_control_input = 1'b0;
    o_inhibit_input = 1'b0;
  end
  // set both pins together, clear of the sampling edge
  task automatic drive(input logic ctl, input logic inhibit_input);
    @(negedge i_clk);
    o_control_input = ctl;
    o_inhibit_input = inhibit_input;
  endtask : drive
  // latch reset: both low and held for the given cycles
  task automatic reset_fault(input int unsigned cyc);
    drive(1'b0, 1'b0);
    repeat (cyc) @(negedge i_clk);
  endtask : reset_fault
endmodule : hb_host_model

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clk, rst, ctl, inhibit_input, ot, oc, cl, uv, hs, ls, flt, stby; // bench wires
  hb_fault_pkg::sense_mode_t sense; // sense selection seen
  int fails = 0; // mismatch count
  int n_compared = 0; // comparison count
  int cycles = 0; // timeout counter; whole run is near 6560 cycles
  hb_host_model host (.i_clk(clk), .o_control_input(ctl), .o_inhibit_input(inhibit_input));
  hb_fault_ctrl dut (.i_clk(clk), .i_sys_rst(rst), .i_control_input(ctl),
    .i_inhibit_input(inhibit_input), .i_overtemp(ot), .i_overcurrent(oc), .i_current_limit(cl),
    .i_undervoltage(uv), .o_high_side_switch(hs), .o_low_side_switch(ls),
    .o_sense_output(sense), .o_fault(flt), .o_standby(stby));
  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 12000) begin
      fails++;
      $display("mismatch timeout expected end seen hang");
      final_report();
    end
  end
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report
  // idle cycles, checks land at falling edges where outputs are settled
  task automatic wait_n(input int unsigned n);
    repeat (n) @(negedge clk);
  endtask : wait_n
  task automatic check_bit(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit
  task automatic check_mode(input string what, input logic [1:0] exp, input logic [1:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask : check_mode
  // both low, no fault: stand-by only past the delay, sense floats
  task automatic t_standby();
    host.drive(1'b0, 1'b0);
    wait_n(hb_fault_pkg::STANDBY_CYC - 20);
    check_bit("early standby", 1'b0, stby);
    wait_n(40);
    check_bit("standby", 1'b1, stby);
    check_mode("standby sense", hb_fault_pkg::SENSE_FLOAT, sense);
    host.drive(1'b1, 1'b1);
    wait_n(20);
    $display("test standby done");
  endtask : t_standby
  // overtemperature latches until both pins low for the reset time
  task automatic t_overtemp();
    ot = 1'b1;
    wait_n(10);
    check_bit("ot high side", 1'b0, hs);
    check_bit("ot low side", 1'b0, ls);
    check_mode("ot sense", hb_fault_pkg::SENSE_FAULT, sense);
    ot = 1'b0;
    wait_n(10);
    check_bit("ot latched", 1'b1, flt);
    host.reset_fault(hb_fault_pkg::FAULT_RESET_CYC - 20);
    check_bit("latch early", 1'b1, flt);
    wait_n(40);
    check_bit("latch cleared", 1'b0, flt);
    host.drive(1'b1, 1'b1);
    wait_n(20);
    check_bit("resumed", 1'b1, hs);
    $display("test overtemp done");
  endtask : t_overtemp
  // live overcurrent with both pins low: no stand-by however long
  task automatic t_no_standby();
    host.drive(1'b0, 1'b0);
    oc = 1'b1;
    wait_n(hb_fault_pkg::STANDBY_CYC + 50);
    check_bit("fault standby", 1'b0, stby);
    check_mode("oc sense", hb_fault_pkg::SENSE_FAULT, sense);
    oc = 1'b0;
    wait_n(hb_fault_pkg::FAULT_RESET_CYC + 20);
    check_bit("oc cleared", 1'b0, flt);
    check_bit("standby after clear", 1'b1, stby);
    host.drive(1'b1, 1'b1);
    wait_n(20);
    $display("test no standby done");
  endtask : t_no_standby
  // current limit: swap for the limit time, flag for one and a half times
  task automatic t_climit();
    // held for five cycles: the synchroniser drops anything shorter than two
    cl = 1'b1;
    wait_n(5);
    cl = 1'b0;
    wait_n(15);
    check_mode("cl sense", hb_fault_pkg::SENSE_FAULT, sense);
    wait_n(hb_fault_pkg::CURRENT_LIMIT_CYC - 40);
    check_bit("cl swapped", 1'b1, ls);
    check_bit("cl high side off", 1'b0, hs);
    wait_n(40);
    check_bit("cl resumed", 1'b1, hs);
    wait_n(hb_fault_pkg::CL_FLAG_CYC - hb_fault_pkg::CURRENT_LIMIT_CYC - 40);
    check_mode("cl flag held", hb_fault_pkg::SENSE_FAULT, sense);
    wait_n(40);
    check_mode("cl flag gone", hb_fault_pkg::SENSE_LOAD, sense);
    $display("test current limit done");
  endtask : t_climit
  // undervoltage: low side off and fault while inhibited, high side held off through the recovery delay
  task automatic t_undervolt();
    uv = 1'b1;
    host.drive(1'b1, 1'b0);
    wait_n(20);
    check_bit("uv low side", 1'b0, ls);
    check_bit("uv fault", 1'b1, flt);
    host.drive(1'b1, 1'b1);
    uv = 1'b0;
    wait_n(hb_fault_pkg::UNDERVOLTAGE_CYC - 20);
    check_bit("uv hold", 1'b0, hs);
    wait_n(40);
    check_bit("uv resumed", 1'b1, hs);
    check_bit("uv flag gone", 1'b0, flt);
    $display("test undervoltage done");
  endtask : t_undervolt
  // main sequence: reset 3 cycles, then every scenario in turn
  initial begin
    rst = 1'b1;
    {ot, oc, cl, uv} = 4'h0;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    t_standby();
    t_overtemp();
    t_no_standby();
    t_climit();
    t_undervolt();
    final_report();
  end
endmodule : testbench
